//--- pcsr_map.vh
// Offsets, field positions, fixed values and command codes of the command/status bank
`ifndef PCSR_MAP_VH
`define PCSR_MAP_VH

// ****************************************
// Register offsets (byte addresses in configuration space)
// ****************************************
`define PCSR_OFF_CTRL 8'h04
`define PCSR_OFF_FLAGS 8'h06
`define PCSR_OFF_DWORD 8'h04

// ****************************************
// Control register field positions
// ****************************************
`define PCSR_CTL_IO 0
`define PCSR_CTL_MEM 1
`define PCSR_CTL_MASTER 2
`define PCSR_CTL_SPECIAL 3
`define PCSR_CTL_MWI 4
`define PCSR_CTL_PALETTE 5
`define PCSR_CTL_PARITY 6
`define PCSR_CTL_STEP 7
`define PCSR_CTL_SERR 8
`define PCSR_CTL_B2B 9
`define PCSR_CTL_WRITABLE 16'h0157
`define PCSR_CTL_RESET 16'h0000

// ****************************************
// Condition flag register field positions
// ****************************************
`define PCSR_FLG_CAPCHAIN 4
`define PCSR_FLG_HISPEED 5
`define PCSR_FLG_USERFEAT 6
`define PCSR_FLG_B2BCAP 7
`define PCSR_FLG_MDPAR 8
`define PCSR_FLG_DEVSEL_LO 9
`define PCSR_FLG_DEVSEL_HI 10
`define PCSR_FLG_SIGTABT 11
`define PCSR_FLG_RCVTABT 12
`define PCSR_FLG_RCVMABT 13
`define PCSR_FLG_SIGSERR 14
`define PCSR_FLG_DETPAR 15
`define PCSR_DEVSEL_MEDIUM 2'h1
`define PCSR_FLG_RESET 16'h0210

// ****************************************
// Bus commands for master writes
// ****************************************
`define PCSR_CMD_MEMWRITE 4'h7
`define PCSR_CMD_MWI 4'hF

// ****************************************
// Timing
// ****************************************
`define PCSR_SERR_PULSE_CYCLES 1
`define PCSR_PERR_PULSE_CYCLES 1

`endif

//--- pcsr_flag_bank.v
// Sticky status flags, cleared by writing one, with set taking priority
module pcsr_flag_bank #(
  parameter WIDTH = 6
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [WIDTH-1:0] setPulse,
  input wire [WIDTH-1:0] clearMask,
  output wire [WIDTH-1:0] flags
);

  reg [WIDTH-1:0] flag_ff;
  wire [WIDTH-1:0] nxt_flag;

  // ****************************************
  // One flip-flop per flag
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gFlag
      // Write-one clears
      // Set beats a clear arriving in the same cycle, so no event is lost
      assign nxt_flag[i] = setPulse[i] | (flag_ff[i] & ~clearMask[i]);
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          flag_ff[i] <= 1'b0;
        end else begin
          flag_ff[i] <= nxt_flag[i];
        end
      end
    end
  endgenerate

  assign flags = flag_ff;

endmodule

//--- pcsr_regs.v
// Command and status registers of one function's configuration header
// Notes on behaviour
// - Control bits 15..10 always read zero, writes ignored.
// - No fast back-to-back generation; its control bit reads zero.
// - SERR pin driven only when system error enable set, after address parity error.
// - No address/data stepping; stepping control bit hardwired to zero.
// - PERR pin driven on detected data parity errors only when parity response enabled.
// - No palette snooping; its control bit reads zero.
// - Master writes use write-and-invalidate when enabled and the core says the burst qualifies, else plain memory write.
// - Special cycles ignored; special cycle enable reads zero.
// - Master cycles requested only while bus master enable set.
// - Memory cycles claimed only while memory response enable set.
// - I/O accesses claimed only while I/O enable set.
// - Status flags clear on written one, zero no effect, reads have no side effect.
// - Detected parity flag set on address or data parity error.
// - Signalled system error flag set when SERR enabled and asserted.
// - Received master abort flag set when own master cycle master-aborts.
// - Received target abort flag set when own master cycle is target-aborted.
// - Signalled target abort flag set when this target issues target abort.
// - DEVSEL timing field reads 01b; DEVSEL claimed at medium speed.
// - Master data parity flag needs PERR seen, own data phase, response enabled.
// - Back-to-back capable, user feature and 66 MHz status bits read zero.
// - Capability chain present bit always reads one.
// - Status bits 3..0 read zero.
`include "pcsr_map.vh"

module pcsr_regs (
  input wire sys_clk,
  input wire arst_n,
  // Configuration access port
  input wire cfgWrite,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [3:0] cfgByteEn,
  input wire [31:0] cfgWrData,
  output reg [31:0] cfgRdData,
  output reg cfgAck,
  // Target decode from the bus core
  input wire ioHit,
  input wire memHit,
  output reg devselClaim,
  output reg ioClaim,
  output reg memClaim,
  // Master side
  input wire masterReq,
  input wire masterWriteInvalidateOk,
  output wire busRequest,
  output reg [3:0] masterWriteCmd,
  // Error events from the bus core, one-cycle pulses
  input wire addrParityErr,
  input wire dataParityErr,
  input wire perrSeen,
  input wire masterDataPhase,
  input wire masterAbortRcvd,
  input wire targetAbortRcvd,
  input wire targetAbortSent,
  // Open-drain error pins
  output reg serrOut,
  output reg serrOe,
  output reg perrOut,
  output reg perrOe,
  // Visible control levels
  output wire parityResponseEnable,
  output wire systemErrorDriverEnable,
  output wire [15:0] controlValue,
  output wire [15:0] conditionValue
);

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Both registers share one dword, so one decode serves reads and clears
  localparam [7:0] DWORD_BASE = `PCSR_OFF_DWORD;

  function [31:0] laneMask;
    input [3:0] be;
    begin
      laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  function hitsDword;
    input [7:0] addr;
    begin
      hitsDword = (addr[7:2] == DWORD_BASE[7:2]);
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  reg [15:0] ctrl_ff;
  reg [15:0] nxt_ctrl;
  wire [31:0] wrMask;
  wire ctrlHit;
  wire ctrlWrite;
  wire [5:0] flagSet;
  wire [5:0] flagClear;
  wire [5:0] flagBits;
  wire [15:0] flagWord;
  wire ioEnable;
  wire memEnable;
  wire masterEnable;
  wire mwiEnable;
  wire serrEnable;
  wire perrEnable;
  wire serrFire;
  wire perrFire;

  assign wrMask = laneMask(cfgByteEn);
  assign ctrlHit = hitsDword(cfgAddr);
  assign ctrlWrite = cfgWrite & ctrlHit;

  // ****************************************
  // Control register
  // ****************************************
  // Lanes 2 and 3 of the same write go to the flag clears, not here
  // Only implemented bits are stored; all others are constant zero
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (ctrlWrite) begin
      nxt_ctrl = ((ctrl_ff & ~wrMask[15:0]) | (cfgWrData[15:0] & wrMask[15:0]))
                 & `PCSR_CTL_WRITABLE;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= `PCSR_CTL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign ioEnable = ctrl_ff[`PCSR_CTL_IO];
  assign memEnable = ctrl_ff[`PCSR_CTL_MEM];
  assign masterEnable = ctrl_ff[`PCSR_CTL_MASTER];
  assign mwiEnable = ctrl_ff[`PCSR_CTL_MWI];
  assign perrEnable = ctrl_ff[`PCSR_CTL_PARITY];
  assign serrEnable = ctrl_ff[`PCSR_CTL_SERR];

  assign parityResponseEnable = perrEnable;
  assign systemErrorDriverEnable = serrEnable;
  assign controlValue = ctrl_ff;

  // ****************************************
  // Error pin drivers
  // ****************************************
  // SERR gated by enable
  assign serrFire = serrEnable & addrParityErr;
  assign perrFire = perrEnable & dataParityErr;

  // Pins are open drain: output held low, enable carries the assertion
  // Each enable lasts one clock per event; the bus pull-up ends the assertion
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      serrOut <= 1'b0;
      serrOe <= 1'b0;
    end else begin
      serrOut <= 1'b0;
      serrOe <= serrFire;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      perrOut <= 1'b0;
      perrOe <= 1'b0;
    end else begin
      perrOut <= 1'b0;
      perrOe <= perrFire;
    end
  end

  // ****************************************
  // Condition flags
  // ****************************************
  // Flag bank order: 0 mdpar, 1 sigtabt, 2 rcvtabt, 3 rcvmabt, 4 sigserr, 5 detpar
  // Master data parity condition
  assign flagSet[0] = perrSeen & masterDataPhase & perrEnable;
  assign flagSet[1] = targetAbortSent;
  assign flagSet[2] = targetAbortRcvd;
  assign flagSet[3] = masterAbortRcvd;
  assign flagSet[4] = serrFire;
  assign flagSet[5] = addrParityErr | dataParityErr;

  assign flagClear[0] = ctrlWrite & wrMask[16 + `PCSR_FLG_MDPAR]
                        & cfgWrData[16 + `PCSR_FLG_MDPAR];
  assign flagClear[1] = ctrlWrite & wrMask[16 + `PCSR_FLG_SIGTABT]
                        & cfgWrData[16 + `PCSR_FLG_SIGTABT];
  assign flagClear[2] = ctrlWrite & wrMask[16 + `PCSR_FLG_RCVTABT]
                        & cfgWrData[16 + `PCSR_FLG_RCVTABT];
  assign flagClear[3] = ctrlWrite & wrMask[16 + `PCSR_FLG_RCVMABT]
                        & cfgWrData[16 + `PCSR_FLG_RCVMABT];
  assign flagClear[4] = ctrlWrite & wrMask[16 + `PCSR_FLG_SIGSERR]
                        & cfgWrData[16 + `PCSR_FLG_SIGSERR];
  assign flagClear[5] = ctrlWrite & wrMask[16 + `PCSR_FLG_DETPAR]
                        & cfgWrData[16 + `PCSR_FLG_DETPAR];

  // Set and clear meet in the bank, where the set wins
  pcsr_flag_bank #(
    .WIDTH(6)
  ) uFlags (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .setPulse(flagSet),
    .clearMask(flagClear),
    .flags(flagBits)
  );

  // ****************************************
  // Condition word assembly
  // ****************************************
  // Clearable flags from the bank
  assign flagWord[`PCSR_FLG_DETPAR] = flagBits[5];
  assign flagWord[`PCSR_FLG_SIGSERR] = flagBits[4];
  assign flagWord[`PCSR_FLG_RCVMABT] = flagBits[3];
  assign flagWord[`PCSR_FLG_RCVTABT] = flagBits[2];
  assign flagWord[`PCSR_FLG_SIGTABT] = flagBits[1];
  assign flagWord[`PCSR_FLG_MDPAR] = flagBits[0];
  assign flagWord[`PCSR_FLG_DEVSEL_HI:`PCSR_FLG_DEVSEL_LO] = `PCSR_DEVSEL_MEDIUM;
  assign flagWord[`PCSR_FLG_B2BCAP] = 1'b0;
  assign flagWord[`PCSR_FLG_USERFEAT] = 1'b0;
  assign flagWord[`PCSR_FLG_HISPEED] = 1'b0;
  assign flagWord[`PCSR_FLG_CAPCHAIN] = 1'b1;
  assign flagWord[3:0] = 4'h0;
  assign conditionValue = flagWord;

  // ****************************************
  // Configuration read path
  // ****************************************
  // Reads have no side effect; unmapped offsets return zero with an acknowledge
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgRdData <= 32'h0000_0000;
      cfgAck <= 1'b0;
    end else begin
      cfgAck <= cfgRead | cfgWrite;
      if (cfgRead) begin
        if (ctrlHit) begin
          cfgRdData <= {flagWord, ctrl_ff} & laneMask(cfgByteEn);
        end else begin
          cfgRdData <= 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************
  // Target claim
  // ****************************************
  // Claim is registered one clock after decode, which is medium DEVSEL timing
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ioClaim <= 1'b0;
      memClaim <= 1'b0;
      devselClaim <= 1'b0;
    end else begin
      ioClaim <= ioHit & ioEnable;
      memClaim <= memHit & memEnable;
      devselClaim <= (ioHit & ioEnable) | (memHit & memEnable);
    end
  end

  // ****************************************
  // Master side
  // ****************************************
  // Request gated by master enable
  assign busRequest = masterReq & masterEnable;

  // Write-and-invalidate only where the core says the burst qualifies
  // Registered so the command holds steady through the address phase
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      masterWriteCmd <= `PCSR_CMD_MEMWRITE;
    end else begin
      if (mwiEnable & masterWriteInvalidateOk) begin
        masterWriteCmd <= `PCSR_CMD_MWI;
      end else begin
        masterWriteCmd <= `PCSR_CMD_MEMWRITE;
      end
    end
  end

endmodule

//--- pcsr_regs_monitor.sv
// Assertion checker for the command and status register bank
module pcsr_regs_monitor (
  input wire sys_clk,
  input wire arst_n,
  input wire cfgWrite,
  input wire [7:0] cfgAddr,
  input wire [3:0] cfgByteEn,
  input wire [31:0] cfgWrData,
  input wire ioHit,
  input wire memHit,
  input wire devselClaim,
  input wire ioClaim,
  input wire memClaim,
  input wire masterReq,
  input wire masterWriteInvalidateOk,
  input wire busRequest,
  input wire [3:0] masterWriteCmd,
  input wire addrParityErr,
  input wire dataParityErr,
  input wire perrSeen,
  input wire masterDataPhase,
  input wire masterAbortRcvd,
  input wire targetAbortRcvd,
  input wire targetAbortSent,
  input wire serrOe,
  input wire perrOe,
  input wire [15:0] controlValue,
  input wire [15:0] conditionValue
);
  // ********
  // Properties
  // ********
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_addrErr;
    addrParityErr && controlValue[8];
  endsequence
  // No parity event, so a same-cycle set cannot mask the clear
  sequence s_clrTop;
    cfgWrite && cfgAddr[7:2] == 6'h01 && cfgByteEn[3] && cfgWrData[31]
      && !addrParityErr && !dataParityErr;
  endsequence
  property p_ctlFixed;
    (controlValue & 16'hFEA8) == 16'h0000;
  endproperty
  a_ctlFixed: assert property (p_ctlFixed) else $error("control fixed bits");
  property p_flgFixed;
    (conditionValue & 16'h06FF) == 16'h0210;
  endproperty
  a_flgFixed: assert property (p_flgFixed) else $error("status fixed bits");
  property p_serr;
    s_addrErr |=> serrOe && conditionValue[15:14] == 2'h3;
  endproperty
  a_serr: assert property (p_serr) else $error("serr drive or flag");
  property p_perr;
    perrOe |-> $past(dataParityErr && controlValue[6]);
  endproperty
  a_perr: assert property (p_perr) else $error("perr drive");
  property p_cmd;
    masterWriteCmd == ($past(controlValue[4] && masterWriteInvalidateOk) ? 4'hF : 4'h7);
  endproperty
  a_cmd: assert property (p_cmd) else $error("master write command");
  property p_busReq;
    busRequest == (masterReq && controlValue[2]);
  endproperty
  a_busReq: assert property (p_busReq) else $error("bus request gating");
  property p_claim;
    memClaim == $past(memHit && controlValue[1]) && ioClaim == $past(ioHit && controlValue[0])
      && devselClaim == (memClaim || ioClaim);
  endproperty
  a_claim: assert property (p_claim) else $error("target claim gating");
  property p_clr;
    s_clrTop |=> !conditionValue[15];
  endproperty
  a_clr: assert property (p_clr) else $error("write one clear");
  property p_detpar;
    (addrParityErr || dataParityErr) |=> conditionValue[15];
  endproperty
  a_detpar: assert property (p_detpar) else $error("parity flag");
  property p_abort;
    (masterAbortRcvd || targetAbortRcvd || targetAbortSent) |=>
      (~conditionValue[13:11] & $past({masterAbortRcvd, targetAbortRcvd, targetAbortSent})) == 3'h0;
  endproperty
  a_abort: assert property (p_abort) else $error("abort flags");
  property p_mdpar;
    $rose(conditionValue[8]) |-> $past(perrSeen && masterDataPhase && controlValue[6]);
  endproperty
  a_mdpar: assert property (p_mdpar) else $error("master data parity flag");
endmodule

bind pcsr_regs pcsr_regs_monitor u_mon (.*);

//--- pcsr_bus_agent.sv
// Far-side agent: target decode, master replies and bus error events
module pcsr_bus_agent #(
  parameter SEED = 35199
) (
  input wire sys_clk,
  input wire [3:0] density,
  output logic [10:0] events
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = SEED;
  integer i;
  initial events = 11'h000;
  // Low density is a slow bus; flags then sit long enough for clears to matter
  always @(negedge sys_clk) begin
    for (i = 0; i < 11; i++) begin
      events[i] <= ($random(seed) & 15) < density;
    end
  end
endmodule

//--- tb.sv
// Self-checking bench with a cycle model of the command and status bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, arst_n = 0, cfgWrite = 0, cfgRead = 0;
  logic [7:0] cfgAddr = 8'h00;
  logic [3:0] cfgByteEn = 4'h0, density = 4'h2;
  logic [31:0] cfgWrData = 32'h0000_0000, n;
  logic [10:0] ev;
  wire [31:0] cfgRdData;
  wire [3:0] masterWriteCmd;
  wire cfgAck, devselClaim, ioClaim, memClaim, busRequest, serrOe, perrOe;
  wire serrOut, perrOut, parityResponseEnable, systemErrorDriverEnable;
  wire [15:0] controlValue, conditionValue;
  integer seed = 35199, miscompares = 0, samplesChecked = 0, k;
  logic [15:0] mCtl, mFlg, mSet;
  logic [31:0] mRd;
  logic [3:0] mCmd;
  logic mAck, mIo, mMem, mSerr, mPerr;
  pcsr_bus_agent u_agent (.sys_clk(sys_clk), .density(density), .events(ev));
  pcsr_regs u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgAck(cfgAck), .ioHit(ev[0]), .memHit(ev[1]), .devselClaim(devselClaim),
    .ioClaim(ioClaim), .memClaim(memClaim), .masterReq(ev[2]),
    .masterWriteInvalidateOk(ev[3]), .busRequest(busRequest), .masterWriteCmd(masterWriteCmd),
    .addrParityErr(ev[4]), .dataParityErr(ev[5]), .perrSeen(ev[6]), .masterDataPhase(ev[7]),
    .masterAbortRcvd(ev[8]), .targetAbortRcvd(ev[9]), .targetAbortSent(ev[10]),
    .serrOut(serrOut), .serrOe(serrOe), .perrOut(perrOut), .perrOe(perrOe),
    .parityResponseEnable(parityResponseEnable),
    .systemErrorDriverEnable(systemErrorDriverEnable), .controlValue(controlValue),
    .conditionValue(conditionValue));
  always #12.5 sys_clk = ~sys_clk;
  // ********
  // Checking
  // ********
  task chkWord(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task chkPin(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t pin got %b expected %b", $time, got, exp);
    end
  endtask
  task endSim;
    if (miscompares == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Model reads old state first, so every output sees pre-edge values
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mCtl = 16'h0000;
      mFlg = 16'h0000;
      mRd = 32'h0000_0000;
      mCmd = 4'h7;
      {mAck, mIo, mMem, mSerr, mPerr} = 5'h00;
    end else begin
      mSet = {ev[4] | ev[5], ev[4] & mCtl[8], ev[8], ev[9], ev[10], 2'h0,
        ev[6] & ev[7] & mCtl[6], 8'h00};
      if (cfgRead)
        mRd = (cfgAddr[7:2] == 6'h01) ? {mFlg | 16'h0210, mCtl} & {{8{cfgByteEn[3]}},
          {8{cfgByteEn[2]}}, {8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}} : 32'h0000_0000;
      mAck = cfgWrite | cfgRead;
      mCmd = (mCtl[4] & ev[3]) ? 4'hF : 4'h7;
      mIo = ev[0] & mCtl[0];
      mMem = ev[1] & mCtl[1];
      mSerr = ev[4] & mCtl[8];
      mPerr = ev[5] & mCtl[6];
      if (cfgWrite && cfgAddr[7:2] == 6'h01) begin
        mFlg = mFlg & ~(cfgWrData[31:16] & {{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}}} & 16'hF900);
        if (cfgByteEn[0]) mCtl[7:0] = cfgWrData[7:0] & 8'h57;
        if (cfgByteEn[1]) mCtl[8] = cfgWrData[8];
      end
      mFlg = mFlg | mSet;
    end
  end
  always @(negedge sys_clk) begin
    chkWord({controlValue, conditionValue}, {mCtl, mFlg | 16'h0210});
    chkPin(cfgAck, mAck);
    chkPin(busRequest, ev[2] & mCtl[2]);
    chkWord({28'h000_0000, serrOut, perrOut, parityResponseEnable, systemErrorDriverEnable},
      {28'h000_0000, 2'h0, mCtl[6], mCtl[8]});
    chkWord(cfgRdData, mRd);
    chkWord({23'h00_0000, masterWriteCmd, devselClaim, ioClaim, memClaim, serrOe, perrOe},
      {23'h00_0000, mCmd, mIo | mMem, mIo, mMem, mSerr, mPerr});
  end
  // ********
  // Stimulus
  // ********
  initial begin
    repeat (10) @(negedge sys_clk);
    arst_n <= 1;
    for (k = 0; k < 6000; k++) begin
      @(negedge sys_clk);
      n = $random(seed);
      if (k == 3000) arst_n <= 0;
      if (k == 3002) arst_n <= 1;
      density <= (k < 3000) ? 4'h2 : 4'h6;
      cfgWrite <= (k < 3000 || k > 3001) && n[1:0] == 2'h1;
      cfgRead <= (k < 3000 || k > 3001) && n[1:0] == 2'h2;
      // Half the time the mapped dword, otherwise anywhere to hit unmapped reads
      cfgAddr <= n[2] ? {6'h01, n[4:3]} : n[12:5];
      cfgByteEn <= n[16:13];
      cfgWrData <= $random(seed);
    end
    endSim();
  end
  initial begin
    #(7000 * 25);
    miscompares++;
    endSim();
  end
endmodule
